// File: hw/aux_timing_pkg.sv
package aux_timing_pkg;
    localparam int CNT_W = 36;
    localparam int LEN_W = 32;
    localparam int DIV_W = 10;
    localparam int BLK_W = 9;
    localparam int ROW_W = 5;
    localparam logic [DIV_W-1:0] DIV_MIN = 10'h004;
    localparam logic [DIV_W-1:0] DIV_MAX = 10'h200;
    localparam logic [CNT_W-1:0] GRAN_BITS = 36'h000000080;
    localparam logic [CNT_W-1:0] SYNC_GUARD = 36'h000000087;
    localparam logic [CNT_W-1:0] SYNC_MIN = 36'h000000001;
    localparam logic [CNT_W-1:0] ZERO_BITS = 36'h000000000;
    localparam logic [CNT_W-1:0] EFF_MIN = 36'h000000200;
    localparam logic [CNT_W-1:0] STEP_MASK = 36'hFFFFFFFF8;
    localparam logic [CNT_W-1:0] CAP_REG = 36'h7FFFFFF80;
    localparam logic [CNT_W-1:0] CAP_MIX = 36'h08FFFFF80;
    localparam logic [CNT_W-1:0] LCM_LIMIT = 36'h800000000;
    localparam logic [CNT_W-1:0] MIX_LIMIT = 36'h090000000;
    localparam logic [2:0] GRAN_LOG2 = 3'h7;
    localparam logic [CNT_W-1:0] EFF_RST = 36'h000000200;
    localparam logic [CNT_W-1:0] LCM_RST = 36'h000000200;
    localparam logic [CNT_W-1:0] CYCLE_RST = 36'h000000080;

    typedef enum logic [1:0] {
        AUX_DIV = 2'h0,
        AUX_SYNC = 2'h1,
        AUX_BURST2 = 2'h2
    } aux_sel_type;

    typedef enum logic [2:0] {
        PAT_PRBS = 3'h0,
        PAT_ZSUB = 3'h1,
        PAT_DATA = 3'h2,
        PAT_PROGRAMMABLE_WORD = 3'h3,
        PAT_MIXED = 3'h4
    } pattern_kind_type;

    typedef enum logic {
        GATE_BURST = 1'b0,
        GATE_REPEAT = 1'b1
    } gate_mode_type;

    typedef enum logic [1:0] {
        CALC_IDLE = 2'b00,
        CALC_GROW = 2'b01,
        CALC_LCM = 2'b11
    } calc_state_type;
endpackage

// File: hw/aux_timing_output_generator.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Aux output selects divided clock, sync, burst2
// - Sync position 1 to LCM minus 135, 8-steps
// - Short patterns repeat until at least 512 bits
// - Mixed sync placed by block and row number
// - Burst2 delay and width up to cycle minus 128
// - Burst gate width 128 up to cycle minus 128
// - Repeat period is length truncated to 128 multiple, or total if mixed, at least 128
// - Repeat width 128 to LCM minus 128, capped
// - Mixed repeat width up to total minus 128, capped
// - Repeat delay uses the same range as width
// - Gating output is low while enabled and inside the gate window
module aux_timing_output_generator (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bit_tick,
    input wire logic pattern_start,
    input wire logic burst_start,
    input wire logic row_start,
    input wire logic [aux_timing_pkg::BLK_W-1:0] cur_block,
    input wire logic [aux_timing_pkg::ROW_W-1:0] cur_row,
    input wire logic cfg_load,
    input wire aux_timing_pkg::pattern_kind_type pattern_kind,
    input wire logic [aux_timing_pkg::LEN_W-1:0] pattern_len,
    input wire logic [aux_timing_pkg::LEN_W-1:0] row_len,
    input wire logic [aux_timing_pkg::ROW_W-1:0] row_count,
    input wire logic [aux_timing_pkg::BLK_W-1:0] block_count,
    input wire logic aux_on,
    input wire aux_timing_pkg::aux_sel_type aux_sel,
    input wire logic [aux_timing_pkg::DIV_W-1:0] div_n,
    input wire logic [aux_timing_pkg::CNT_W-1:0] sync_pos,
    input wire logic [aux_timing_pkg::BLK_W-1:0] sync_block,
    input wire logic [aux_timing_pkg::ROW_W-1:0] sync_row,
    input wire logic [aux_timing_pkg::CNT_W-1:0] burst_cycle,
    input wire logic [aux_timing_pkg::CNT_W-1:0] burst2_delay,
    input wire logic [aux_timing_pkg::CNT_W-1:0] burst2_width,
    input wire logic gate_on,
    input wire aux_timing_pkg::gate_mode_type gate_mode,
    input wire logic [aux_timing_pkg::CNT_W-1:0] gate_delay,
    input wire logic [aux_timing_pkg::CNT_W-1:0] gate_width,
    input wire logic [aux_timing_pkg::CNT_W-1:0] repeat_delay,
    input wire logic [aux_timing_pkg::CNT_W-1:0] repeat_width,
    output logic aux_out,
    output logic gate_out_n,
    output logic [aux_timing_pkg::CNT_W-1:0] eff_len,
    output logic calc_busy
);
    import aux_timing_pkg::*;

    typedef struct packed {
        calc_state_type calc;
        logic [CNT_W-1:0] eff;
        logic [CNT_W-1:0] lcm;
        logic [CNT_W-1:0] total;
        logic [CNT_W-1:0] cycle;
        logic [CNT_W-1:0] pat_cnt;
        logic [CNT_W-1:0] burst_cnt;
        logic [CNT_W-1:0] rep_cnt;
        logic [DIV_W-2:0] div_cnt;
        logic div_lvl;
        logic sync_lvl;
        logic aux_lvl;
        logic gate_lvl;
        logic aux_out;
        logic gate_out_n;
        logic busy;
    } state_type;

    state_type s_reg;
    state_type s_next;

    function automatic logic [CNT_W-1:0] sat_sub(input logic [CNT_W-1:0] a,
                                                 input logic [CNT_W-1:0] b);
        return (a > b) ? a - b : ZERO_BITS;
    endfunction

    // Clamp into [lo, hi], then round down onto the 8-bit grid from lo
    function automatic logic [CNT_W-1:0] snap(input logic [CNT_W-1:0] v,
                                              input logic [CNT_W-1:0] lo,
                                              input logic [CNT_W-1:0] hi);
        logic [CNT_W-1:0] c;
        c = (v > hi) ? hi : v;
        if (c < lo || hi < lo) begin
            c = lo;
        end
        return lo + ((c - lo) & STEP_MASK);
    endfunction

    function automatic logic in_win(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] d,
                                    input logic [CNT_W-1:0] w);
        return (cnt >= d) && ((cnt - d) < w);
    endfunction

    function automatic logic [2:0] low_zeros(input logic [CNT_W-1:0] v);
        logic [2:0] n;
        n = GRAN_LOG2;
        for (int i = 6; i >= 0; i--) begin
            if (v[i]) begin
                n = 3'(i);
            end
        end
        return n;
    endfunction

    logic mixed;
    logic [CNT_W-1:0] sync_eff;
    logic [CNT_W-1:0] burst_hi;
    logic [CNT_W-1:0] b2_d;
    logic [CNT_W-1:0] b2_w;
    logic [CNT_W-1:0] g_d;
    logic [CNT_W-1:0] g_w;
    logic [CNT_W-1:0] rep_hi;
    logic [CNT_W-1:0] rep_d;
    logic [CNT_W-1:0] rep_w;
    logic [DIV_W-1:0] div_eff;
    logic [43:0] lcm_wide;
    logic [47:0] mix_wide;

    assign mixed = (pattern_kind == PAT_MIXED);
    assign sync_eff = snap(sync_pos, SYNC_MIN, sat_sub(s_reg.lcm, SYNC_GUARD));
    assign burst_hi = sat_sub(burst_cycle, GRAN_BITS);
    assign b2_d = snap(burst2_delay, ZERO_BITS, burst_hi);
    assign b2_w = snap(burst2_width, ZERO_BITS, burst_hi);
    assign g_d = snap(gate_delay, ZERO_BITS, burst_hi);
    assign g_w = snap(gate_width, GRAN_BITS, burst_hi);
    always_comb begin
        rep_hi = sat_sub(s_reg.lcm, GRAN_BITS);
        if (rep_hi > CAP_REG) begin
            rep_hi = CAP_REG;
        end
        if (mixed) begin
            rep_hi = sat_sub(s_reg.total, GRAN_BITS);
            if (rep_hi > CAP_MIX) begin
                rep_hi = CAP_MIX;
            end
        end
    end
    assign rep_w = snap(repeat_width, GRAN_BITS, rep_hi);
    assign rep_d = snap(repeat_delay, GRAN_BITS, rep_hi);
    assign div_eff = ((div_n < DIV_MIN) ? DIV_MIN : (div_n > DIV_MAX) ? DIV_MAX : div_n)
                     & ~10'h001;
    assign lcm_wide = {8'h00, s_reg.eff} << (GRAN_LOG2 - low_zeros(s_reg.eff));
    assign mix_wide = {16'h0000, row_len} * {43'h00000000000, row_count}
                      * {39'h0000000000, block_count};

    always_comb begin
        s_next = s_reg;
        case (s_reg.calc)
            CALC_IDLE: begin
                if (cfg_load) begin
                    s_next.eff = (pattern_len == 32'h00000000) ? EFF_MIN
                                 : {4'h0, pattern_len};
                    s_next.calc = CALC_GROW;
                    s_next.busy = 1'b1;
                end
            end
            CALC_GROW: begin
                if (s_reg.eff < EFF_MIN) begin
                    s_next.eff = s_reg.eff + {4'h0, pattern_len};
                end else begin
                    s_next.calc = CALC_LCM;
                end
            end
            CALC_LCM: begin
                s_next.lcm = (lcm_wide > {8'h00, LCM_LIMIT}) ? LCM_LIMIT
                             : lcm_wide[CNT_W-1:0];
                s_next.total = (mix_wide > {12'h000, MIX_LIMIT}) ? MIX_LIMIT
                               : mix_wide[CNT_W-1:0];
                s_next.cycle = {4'h0, pattern_len[LEN_W-1:7], 7'h00};
                if (mixed) begin
                    s_next.cycle = s_next.total;
                end
                if (s_next.cycle < GRAN_BITS) begin
                    s_next.cycle = GRAN_BITS;
                end
                s_next.calc = CALC_IDLE;
                s_next.busy = 1'b0;
            end
            default: begin
                s_next.calc = CALC_IDLE;
                s_next.busy = 1'b0;
            end
        endcase

        if (bit_tick) begin
            // Output levels follow the counter value of this bit
            s_next.sync_lvl = mixed
                ? (row_start && cur_block == sync_block && cur_row == sync_row)
                : (s_reg.pat_cnt == sync_eff - SYNC_MIN);
            if (s_reg.div_cnt + 9'h001 >= div_eff[DIV_W-1:1]) begin
                s_next.div_cnt = '0;
                s_next.div_lvl = ~s_reg.div_lvl;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 9'h001;
            end
            case (aux_sel)
                AUX_DIV: s_next.aux_lvl = s_next.div_lvl;
                AUX_SYNC: s_next.aux_lvl = s_next.sync_lvl;
                AUX_BURST2: s_next.aux_lvl = in_win(s_reg.burst_cnt, b2_d, b2_w);
                default: s_next.aux_lvl = 1'b0;
            endcase
            if (gate_mode == GATE_BURST) begin
                s_next.gate_lvl = in_win(s_reg.burst_cnt, g_d, g_w);
            end else begin
                s_next.gate_lvl = in_win(s_reg.rep_cnt, rep_d, rep_w);
            end
            if (pattern_start) begin
                s_next.pat_cnt = '0;
                s_next.rep_cnt = '0;
            end else begin
                s_next.pat_cnt = (s_reg.pat_cnt + 36'h1 >= s_reg.lcm) ? '0
                                 : s_reg.pat_cnt + 36'h1;
                s_next.rep_cnt = (s_reg.rep_cnt + 36'h1 >= s_reg.cycle) ? '0
                                 : s_reg.rep_cnt + 36'h1;
            end
            if (burst_start) begin
                s_next.burst_cnt = '0;
            end else if (s_reg.burst_cnt != {CNT_W{1'b1}}) begin
                s_next.burst_cnt = s_reg.burst_cnt + 36'h1;
            end
        end
        s_next.aux_out = aux_on && s_next.aux_lvl;
        s_next.gate_out_n = !(gate_on && s_next.gate_lvl);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '{calc: CALC_IDLE, eff: EFF_RST, lcm: LCM_RST, total: EFF_RST,
                       cycle: CYCLE_RST, gate_out_n: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign aux_out = s_reg.aux_out;
    assign gate_out_n = s_reg.gate_out_n;
    assign eff_len = s_reg.eff;
    assign calc_busy = s_reg.busy;

    property p_aux_off;
        @(posedge sys_clk) disable iff (!rst_b) !aux_on |=> !aux_out;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux out high while off");

    property p_gate_idle_high;
        @(posedge sys_clk) disable iff (!rst_b) !gate_on |=> gate_out_n;
    endproperty
    a_gate_idle_high: assert property (p_gate_idle_high) else $error("gate low while off");

    property p_eff_min;
        @(posedge sys_clk) disable iff (!rst_b)
            !calc_busy && !cfg_load && pattern_len != 32'h0 |-> eff_len >= EFF_MIN
            && (eff_len == {4'h0, pattern_len} || eff_len - {4'h0, pattern_len} < EFF_MIN);
    endproperty
    a_eff_min: assert property (p_eff_min) else $error("effective length wrong");

    property p_calc_done;
        @(posedge sys_clk) disable iff (!rst_b)
            $rose(calc_busy) |-> ##[1:600] !calc_busy;
    endproperty
    a_calc_done: assert property (p_calc_done) else $error("length calc stuck");

    property p_reload;
        @(posedge sys_clk) disable iff (!rst_b)
            bit_tick && pattern_start
            |=> s_reg.pat_cnt == ZERO_BITS && s_reg.rep_cnt == ZERO_BITS;
    endproperty
    a_reload: assert property (p_reload) else $error("pattern counter not reloaded");

    property p_sync_pos;
        @(posedge sys_clk) disable iff (!rst_b)
            aux_on && aux_sel == AUX_SYNC && !mixed && bit_tick
            && s_reg.pat_cnt == sync_eff - SYNC_MIN |=> aux_out;
    endproperty
    a_sync_pos: assert property (p_sync_pos) else $error("sync pulse missing");

    property p_mixed_sync;
        @(posedge sys_clk) disable iff (!rst_b)
            aux_on && aux_sel == AUX_SYNC && mixed && bit_tick && row_start
            && cur_block == sync_block && cur_row == sync_row |=> aux_out;
    endproperty
    a_mixed_sync: assert property (p_mixed_sync) else $error("mixed sync missing");

    property p_burst2_win;
        @(posedge sys_clk) disable iff (!rst_b)
            aux_on && aux_sel == AUX_BURST2 && bit_tick
            && in_win(s_reg.burst_cnt, b2_d, b2_w) |=> aux_out;
    endproperty
    a_burst2_win: assert property (p_burst2_win) else $error("burst2 pulse missing");

    property p_burst_gate;
        @(posedge sys_clk) disable iff (!rst_b)
            gate_on && gate_mode == GATE_BURST && bit_tick && s_reg.burst_cnt == g_d
            && g_w >= GRAN_BITS |=> !gate_out_n;
    endproperty
    a_burst_gate: assert property (p_burst_gate) else $error("burst gate not enabled");

    property p_rep_range;
        @(posedge sys_clk) disable iff (!rst_b)
            rep_w >= GRAN_BITS && rep_d >= GRAN_BITS
            && rep_w <= (mixed ? CAP_MIX : CAP_REG) && rep_w[2:0] == 3'h0;
    endproperty
    a_rep_range: assert property (p_rep_range) else $error("repeat range bad");

    property p_rep_cycle;
        @(posedge sys_clk) disable iff (!rst_b)
            !calc_busy && !cfg_load && !mixed && pattern_len >= 32'h80
            |-> s_reg.cycle[6:0] == 7'h00
            && s_reg.cycle <= {4'h0, pattern_len} && {4'h0, pattern_len} - s_reg.cycle < GRAN_BITS;
    endproperty
    a_rep_cycle: assert property (p_rep_cycle) else $error("repeat period wrong");
endmodule
`default_nettype wire

// File: tb/fixture_model.sv
`timescale 1ns/1ns
`default_nettype none
module fixture_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bit_tick,
    input wire logic aux_out,
    input wire logic gate_out_n,
    input wire logic clr,
    output logic [31:0] aux_hi,
    output logic [31:0] gate_lo
);
    // Levels are seen once per bit period
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_hi <= '0;
            gate_lo <= '0;
        end else if (clr) begin
            aux_hi <= '0;
            gate_lo <= '0;
        end else if (bit_tick) begin
            aux_hi <= aux_hi + {31'h0, aux_out};
            gate_lo <= gate_lo + {31'h0, ~gate_out_n};
        end
    end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import aux_timing_pkg::*;
    logic sys_clk = 0, rst_b = 0, bit_tick = 0, pattern_start = 0, burst_start = 0;
    logic row_start = 0, cfg_load = 0, aux_on = 1, gate_on = 1, clr = 0;
    logic [BLK_W-1:0] cur_block = 1, block_count = 1, sync_block = 1;
    logic [ROW_W-1:0] cur_row = 1, row_count = 1, sync_row = 1;
    pattern_kind_type pattern_kind = PAT_PRBS;
    aux_sel_type aux_sel = AUX_DIV;
    gate_mode_type gate_mode = GATE_BURST;
    logic [LEN_W-1:0] pattern_len = 128, row_len = 2048;
    logic [DIV_W-1:0] div_n = 4;
    logic [CNT_W-1:0] sync_pos = 1, burst_cycle = 1024, burst2_delay = 0, burst2_width = 0;
    logic [CNT_W-1:0] gate_delay = 0, gate_width = 128, repeat_delay = 128, repeat_width = 128;
    logic aux_out, gate_out_n, calc_busy;
    logic [CNT_W-1:0] eff_len, w;
    logic [31:0] aux_hi, gate_lo;
    integer errors = 0, n_tests = 0, seed = 32'h4767A106;
    int i, n;
    int lens[6] = '{7, 100, 511, 512, 1000, 0};

    always #10 sys_clk = ~sys_clk;

    aux_timing_output_generator aux_timing_output_generator_i (.sys_clk, .rst_b, .bit_tick,
        .pattern_start, .burst_start, .row_start, .cur_block, .cur_row, .cfg_load,
        .pattern_kind, .pattern_len, .row_len, .row_count, .block_count, .aux_on, .aux_sel,
        .div_n, .sync_pos, .sync_block, .sync_row, .burst_cycle, .burst2_delay, .burst2_width,
        .gate_on, .gate_mode, .gate_delay, .gate_width, .repeat_delay, .repeat_width,
        .aux_out, .gate_out_n, .eff_len, .calc_busy);
    fixture_model fixture_model_i (.sys_clk, .rst_b, .bit_tick, .aux_out, .gate_out_n,
        .clr, .aux_hi, .gate_lo);

    function automatic logic [CNT_W-1:0] eff(input logic [LEN_W-1:0] len);
        logic [CNT_W-1:0] m;
        if (len == 0) return EFF_MIN;
        m = CNT_W'(len);
        while (m < EFF_MIN) m = m + CNT_W'(len);
        return m;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask

    task automatic tick(input logic ps, input logic bs);
        @(posedge sys_clk);
        #2;
        bit_tick = 1;
        pattern_start = ps;
        burst_start = bs;
        @(posedge sys_clk);
        #2;
        bit_tick = 0;
        pattern_start = 0;
        burst_start = 0;
    endtask

    task automatic run(input int cnt, input int pc, input int bc);
        for (int k = 0; k < cnt; k++) tick(pc != 0 && k % pc == 0, bc != 0 && k % bc == 0);
    endtask

    // Warm up so the window starts in steady state, then count
    task automatic measure(input int warm, input int cnt, input int pc, input int bc);
        run(warm, pc, bc);
        clr = 1;
        @(posedge sys_clk);
        #2;
        clr = 0;
        run(cnt, pc, bc);
    endtask

    task automatic load(input logic [LEN_W-1:0] len);
        int k;
        pattern_len = len;
        cfg_load = 1;
        @(posedge sys_clk);
        #2;
        cfg_load = 0;
        for (k = 0; k < 600 && calc_busy !== 1'b0; k++) begin
            @(posedge sys_clk);
            #2;
        end
        if (k == 600) begin
            errors++;
            $display("BAD t=%0t length calc hang", $time);
            tally_and_finish();
        end
        chk(eff_len, eff(len), "eff_len");
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        #2;
        chk({35'h0, aux_out}, ZERO_BITS, "reset aux_out");
        chk({35'h0, gate_out_n}, SYNC_MIN, "reset gate_out_n");
        chk(eff_len, EFF_RST, "reset eff_len");
        rst_b = 1;
        lens[5] = ($random(seed) & 32'h1FF) + 1;
        for (i = 0; i < 6; i++) load(LEN_W'(lens[i]));
        $display("length test done");
        load(128);
        for (i = 0; i < 3; i++) begin
            n = (i == 0) ? 4 : (i == 1) ? 512 : ($random(seed) & 32'h1E) + 4;
            div_n = DIV_W'(n);
            measure(n, 4 * n, 0, 0);
            chk(CNT_W'(aux_hi), CNT_W'(2 * n), "divider high count");
        end
        aux_on = 0;
        measure(8, 64, 0, 0);
        chk(CNT_W'(aux_hi), ZERO_BITS, "aux off");
        aux_on = 1;
        $display("divider test done");
        aux_sel = AUX_SYNC;
        for (i = 0; i < 2; i++) begin
            sync_pos = (i == 0) ? 36'h000000179 : CNT_W'(($random(seed) & 32'h1F) * 8 + 1);
            measure(512, 1536, 512, 0);
            chk(CNT_W'(aux_hi), 36'h000000003, "sync pulses");
        end
        $display("sync test done");
        aux_sel = AUX_BURST2;
        for (i = 0; i < 2; i++) begin
            burst2_delay = (i == 0) ? ZERO_BITS : CNT_W'($random(seed) & 32'h1F8);
            burst2_width = (i == 0) ? 36'h000000380 : CNT_W'($random(seed) & 32'h1F8);
            measure(1024, 2048, 0, 1024);
            chk(CNT_W'(aux_hi), 2 * burst2_width, "burst2 width");
        end
        $display("burst2 test done");
        for (i = 0; i < 2; i++) begin
            gate_delay = (i == 0) ? 36'h000000380 : CNT_W'($random(seed) & 32'h1F8);
            gate_width = (i == 0) ? GRAN_BITS : CNT_W'(($random(seed) & 32'hF8) + 128);
            measure(1024, 2048, 0, 1024);
            chk(CNT_W'(gate_lo), 2 * gate_width, "gate burst width");
        end
        gate_on = 0;
        measure(1024, 1024, 0, 1024);
        chk(CNT_W'(gate_lo), ZERO_BITS, "gate off");
        gate_on = 1;
        $display("gate burst test done");
        gate_mode = GATE_REPEAT;
        load(1000);
        for (i = 0; i < 2; i++) begin
            repeat_delay = CNT_W'(($random(seed) & 32'hF8) + 128);
            w = CNT_W'(($random(seed) & 32'hF8) + 128);
            repeat_width = w;
            measure(896, 2688, 0, 0);
            chk(CNT_W'(gate_lo), 3 * w, "repeat width");
        end
        $display("repeat test done");
        pattern_kind = PAT_MIXED;
        aux_sel = AUX_SYNC;
        row_count = 2;
        block_count = 2;
        sync_block = 2;
        sync_row = 1;
        load(128);
        clr = 1;
        @(posedge sys_clk);
        #2;
        clr = 0;
        // Walk all four block and row pairs twice, one row start each
        for (i = 0; i < 8; i++) begin
            cur_block = BLK_W'(i / 2 % 2 + 1);
            cur_row = ROW_W'(i % 2 + 1);
            row_start = 1;
            tick(0, 0);
            row_start = 0;
            run(7, 0, 0);
        end
        chk(CNT_W'(aux_hi), 36'h000000002, "mixed sync pulses");
        row_count = 1;
        block_count = 1;
        load(128);
        repeat_delay = GRAN_BITS;
        repeat_width = {CNT_W{1'b1}};
        w = CNT_W'(row_len) * row_count * block_count - GRAN_BITS;
        measure(16, 2048, 0, 0);
        chk(CNT_W'(gate_lo), w, "mixed repeat width");
        $display("mixed test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
